//--- hdl/ppm_pkg.sv
// constants of the power management capability and control/status words
// How it works
// - aux current field gives max aux current, 111 largest, 000 self powered; reads 000 without cold-standby wake or with a data register
// - capability bit 5 reads 1 only if device-specific init is needed
// - capability bit 3 reads 1 when wake signalling needs the bus clock
// - bit 3 reads 0 when the function cannot wake from any state
// - capability bits 2..0 always read 010
// - strap sampled at power-on: high enables cold-standby wake support
// - control/status word is 16 bits with power state and wake fields
// - wake status bit 15 sets on any wake event, regardless of enable
// - writing 1 to bit 15 clears it and stops wake; 0 does nothing
// - with cold-standby wake bit 15 is sticky, else it defaults to 0
// - bits 15 and 8 survive bus reset with cold standby, else reset 0
// - data scale bits 14..13 are read-only, 00 without a data register
// - data select bits 12..9 are writable, read zero without data register
// - bit 8 enables wake; output driven only when enable and status set
// - power state field reads current state and takes new state writes
`default_nettype none
package ppm_pkg;
    // config space addresses
    localparam logic [7:0] CAP_BASE = 8'h34;
    localparam logic [7:0] CAP_WORD_OFS = 8'h02;
    localparam logic [7:0] CSR_WORD_OFS = 8'h04;
    // capability word fields
    localparam int AUX_LSB = 6;
    localparam int DSI_BIT = 5;
    localparam int CLK_BIT = 3;
    localparam logic [2:0] PM_REVISION = 3'h2;
    // control/status word fields
    localparam int STATUS_BIT = 15;
    localparam int SCALE_LSB = 13;
    localparam int SELECT_LSB = 9;
    localparam int ENABLE_BIT = 8;
    localparam logic [1:0] SCALE_NONE = 2'h0;
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic [1:0] STATE_FULL_POWER = 2'h0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : ppm_pkg
`default_nettype wire

//--- hdl/ppm_regs.sv
// power management capability and control/status words behind config cycles
`timescale 1ns/100ps
`default_nettype none
module ppm_regs
#(
    parameter logic [2:0] AUX_CURRENT = 3'h7,
    parameter bit NEEDS_DEV_INIT = 1'b0,
    parameter bit WAKE_NEEDS_CLOCK = 1'b1,
    parameter bit WAKE_CAPABLE = 1'b1,
    parameter bit DATA_REG_PRESENT = 1'b0
)
(
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic aux_por,
    // strap
    input wire logic cold_standby_strap,
    // configuration access
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    output logic cfg_ack,
    // power management state
    input wire logic wake_event,
    output logic wake_assert,
    output logic [1:0] power_state,
    output logic cold_standby_support
);
    logic hit_cap;
    logic hit_csr;
    logic wr_hi;
    logic wr_lo;
    logic wake_event_status;
    logic wake_event_enable;
    logic wake_out;
    logic [3:0] data_select;
    logic [15:0] power_capability_word;
    logic [15:0] power_control_status_word;
    logic [15:0] next_rdata;

    assign hit_cap = cfg_addr == ppm_pkg::CAP_BASE + ppm_pkg::CAP_WORD_OFS;
    assign hit_csr = cfg_addr == ppm_pkg::CAP_BASE + ppm_pkg::CSR_WORD_OFS;
    assign wr_hi = cfg_wr && hit_csr && cfg_be[1];
    assign wr_lo = cfg_wr && hit_csr && cfg_be[0];

    // **************************************************
    // strap
    // **************************************************
    // caught while power-on reset is held, so the last value before release counts
    always_ff @(posedge clk)
    begin
        if (aux_por)
            cold_standby_support <= cold_standby_strap;
    end

    // **************************************************
    // wake bits
    // **************************************************
    ppm_wake u_wake
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .aux_por(aux_por),
        .sticky_en(cold_standby_support),
        .wake_capable(WAKE_CAPABLE),
        .event_in(wake_event),
        .status_clr(wr_hi && cfg_wdata[ppm_pkg::STATUS_BIT]),
        .enable_wr(wr_hi),
        .enable_wdata(cfg_wdata[ppm_pkg::ENABLE_BIT]),
        .status(wake_event_status),
        .enable(wake_event_enable),
        .wake_out(wake_out)
    );

    always_ff @(posedge clk)
    begin
        if (aux_por)
            wake_assert <= 1'b0;
        else
            wake_assert <= wake_out;
    end

    // **************************************************
    // writable control fields
    // **************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst || aux_por)
            power_state <= ppm_pkg::STATE_FULL_POWER;
        else if (wr_lo)
            power_state <= cfg_wdata[1:0];
    end

    // without a data register the select field is not stored at all
    always_ff @(posedge clk)
    begin
        if (sys_rst || aux_por || !DATA_REG_PRESENT)
            data_select <= ppm_pkg::SELECT_RESET;
        else if (wr_hi)
            data_select <= cfg_wdata[ppm_pkg::SELECT_LSB +: 4];
    end

    // **************************************************
    // read words
    // **************************************************
    always_comb
    begin
        power_capability_word = ppm_pkg::WORD_ZERO;
        if (cold_standby_support && !DATA_REG_PRESENT)
            power_capability_word[ppm_pkg::AUX_LSB +: 3] = AUX_CURRENT;
        power_capability_word[ppm_pkg::DSI_BIT] = NEEDS_DEV_INIT;
        power_capability_word[ppm_pkg::CLK_BIT] = WAKE_NEEDS_CLOCK && WAKE_CAPABLE;
        power_capability_word[2:0] = ppm_pkg::PM_REVISION;
    end

    always_comb
    begin
        power_control_status_word = ppm_pkg::WORD_ZERO;
        power_control_status_word[ppm_pkg::STATUS_BIT] = wake_event_status;
        power_control_status_word[ppm_pkg::SCALE_LSB +: 2] = ppm_pkg::SCALE_NONE;
        power_control_status_word[ppm_pkg::SELECT_LSB +: 4] = data_select;
        power_control_status_word[ppm_pkg::ENABLE_BIT] = wake_event_enable;
        power_control_status_word[1:0] = power_state;
    end

    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = ppm_pkg::WORD_ZERO;
        if (hit_cap)
            next_rdata = power_capability_word;
        else if (hit_csr)
            next_rdata = power_control_status_word;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst || aux_por)
        begin
            cfg_rdata <= ppm_pkg::WORD_ZERO;
            cfg_ack <= 1'b0;
        end
        else
        begin
            cfg_rdata <= cfg_rd ? next_rdata : ppm_pkg::WORD_ZERO;
            cfg_ack <= cfg_rd || cfg_wr;
        end
    end

    chk_revision_reads :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_cap |=> cfg_ack && cfg_rdata[2:0] == 3'h2 && cfg_rdata[4] == 1'b0)
        else $error("revision or reserved capability bit wrong");
    chk_aux_gated :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_cap && !cold_standby_support |=> cfg_rdata[8:6] == 3'h0)
        else $error("aux current reported without cold standby");
    chk_reserved_zero :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_csr |=> cfg_rdata[7:2] == 6'h00 && cfg_rdata[14:13] == 2'h0)
        else $error("reserved or scale bits not zero");
    chk_state_written :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            wr_lo ##1 cfg_rd && hit_csr && !cfg_wr |=> cfg_rdata[1:0] == $past(cfg_wdata[1:0], 2))
        else $error("power state write not read back");
    chk_state_reset :
        assert property (@(posedge clk) sys_rst |=> power_state == 2'h0)
        else $error("power state not reset to full power");
    chk_nonsticky_reset :
        assert property (@(posedge clk) disable iff (aux_por)
            sys_rst && !cold_standby_support |=> !wake_event_status && !wake_event_enable)
        else $error("wake bits survive reset without cold standby");

    // **************************************************
    // read-back and bus checks
    // **************************************************
    chk_aux_reported :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_cap && cold_standby_support && !DATA_REG_PRESENT |=>
                cfg_rdata[ppm_pkg::AUX_LSB +: 3] == AUX_CURRENT)
        else $error("aux current field not reported");
    chk_init_flag :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_cap |=> cfg_rdata[ppm_pkg::DSI_BIT] == NEEDS_DEV_INIT)
        else $error("device init flag wrong");
    chk_clock_flag :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_cap |=> cfg_rdata[ppm_pkg::CLK_BIT] == (WAKE_NEEDS_CLOCK && WAKE_CAPABLE))
        else $error("clock dependence flag wrong");
    chk_select_zero :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_csr && !DATA_REG_PRESENT |=>
                cfg_rdata[ppm_pkg::SELECT_LSB +: 4] == ppm_pkg::SELECT_RESET)
        else $error("data select not zero without data register");
    chk_status_shown :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd && hit_csr |=> cfg_rdata[ppm_pkg::STATUS_BIT] == $past(wake_event_status)
                && cfg_rdata[ppm_pkg::ENABLE_BIT] == $past(wake_event_enable))
        else $error("wake bits not shown in control word");
    chk_enable_written :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            wr_hi && WAKE_CAPABLE |=> wake_event_enable == $past(cfg_wdata[ppm_pkg::ENABLE_BIT]))
        else $error("wake enable write not stored");
    chk_state_held :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            !wr_lo |=> $stable(power_state))
        else $error("power state moved without a write");
    chk_strap_held :
        assert property (@(posedge clk) disable iff (aux_por)
            !aux_por |=> $stable(cold_standby_support))
        else $error("strap latch moved after power-on");
    chk_ack_follows :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            cfg_rd || cfg_wr |=> cfg_ack)
        else $error("config access not acknowledged");
    chk_ack_idle :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            !cfg_rd && !cfg_wr |=> !cfg_ack)
        else $error("acknowledge without an access");
    chk_idle_rdata :
        assert property (@(posedge clk) disable iff (sys_rst || aux_por)
            !cfg_rd |=> cfg_rdata == ppm_pkg::WORD_ZERO)
        else $error("read data not zero outside a read");
    chk_wake_follows :
        assert property (@(posedge clk) disable iff (aux_por)
            wake_out |=> wake_assert)
        else $error("wake output did not follow");
    chk_wake_drops :
        assert property (@(posedge clk) disable iff (aux_por)
            !wake_out |=> !wake_assert)
        else $error("wake output held after drop");
endmodule // ppm_regs
`default_nettype wire

//--- hdl/ppm_wake.sv
// wake event status and enable bits with their sticky behaviour
`timescale 1ns/100ps
`default_nettype none
module ppm_wake
(
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic aux_por,
    // configuration
    input wire logic sticky_en,
    input wire logic wake_capable,
    // event and software access
    input wire logic event_in,
    input wire logic status_clr,
    input wire logic enable_wr,
    input wire logic enable_wdata,
    // state
    output logic status,
    output logic enable,
    output logic wake_out
);
    // a bus reset clears the bits only when they are not sticky
    logic bus_clear;
    assign bus_clear = sys_rst && !sticky_en;

    // **************************************************
    // status
    // **************************************************
    // the set wins over a same-cycle clear so no event is lost
    always_ff @(posedge clk)
    begin
        if (aux_por || bus_clear || !wake_capable)
            status <= 1'b0;
        else if (event_in)
            status <= 1'b1;
        else if (status_clr)
            status <= 1'b0;
    end

    // **************************************************
    // enable
    // **************************************************
    always_ff @(posedge clk)
    begin
        if (aux_por || bus_clear || !wake_capable)
            enable <= 1'b0;
        else if (enable_wr)
            enable <= enable_wdata;
    end

    // registered so the output comes from a flop; rises one cycle after status, but drops at the same edge as status on a clear
    always_ff @(posedge clk)
    begin
        if (aux_por || sys_rst)
            wake_out <= 1'b0;
        else
            wake_out <= status && enable && !status_clr;
    end

    chk_event_sets_status :
        assert property (@(posedge clk) disable iff (aux_por || sys_rst)
            event_in && wake_capable |=> status)
        else $error("wake event did not set status");
    chk_clear_drops_status :
        assert property (@(posedge clk) disable iff (aux_por || sys_rst)
            status_clr && !event_in |=> !status)
        else $error("status not cleared by write of one");
    chk_wake_needs_both :
        assert property (@(posedge clk) disable iff (aux_por || sys_rst)
            wake_out |-> $past(status) && $past(enable))
        else $error("wake asserted without status and enable");
    chk_sticky_survives :
        assert property (@(posedge clk) disable iff (aux_por)
            sys_rst && sticky_en && wake_capable && status && !status_clr |=> status)
        else $error("sticky status lost at bus reset");
endmodule // ppm_wake
`default_nettype wire

//--- sim/pci_power_mgmt_regs_bench.sv
// self-checking bench of the power management words
`timescale 1ns/100ps
`default_nettype none
module pci_power_mgmt_regs_bench;
    localparam logic [7:0] CAP = 8'h36;
    localparam logic [7:0] CSR = 8'h38;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic aux_por = 1'b1;
    logic strap = 1'b1;
    logic cfg_rd = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [1:0] cfg_be = 2'h0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic fire = 1'b0;
    logic wake_event;
    logic [15:0] cfg_rdata;
    logic cfg_ack;
    logic wake_assert;
    logic [1:0] power_state;
    logic cold_standby_support;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    ppm_regs i_dut (.clk(clk), .sys_rst(sys_rst), .aux_por(aux_por), .cold_standby_strap(strap),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .wake_event(wake_event), .wake_assert(wake_assert),
        .power_state(power_state), .cold_standby_support(cold_standby_support));
    ppm_wake_src i_src (.clk(clk), .fire(fire), .wake_event(wake_event));
    always #12.5 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ceiling well above the fewer than a hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk({15'h0000, cfg_ack}, 16'h0001);
        chk(cfg_rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
        chk({15'h0000, cfg_ack}, 16'h0001);
        chk(cfg_rdata, 16'h0000);
    endtask
    task automatic por(input logic s);
        @(negedge clk);
        aux_por = 1'b1;
        sys_rst = 1'b1;
        strap = s;
        repeat (2) @(negedge clk);
        aux_por = 1'b0;
        sys_rst = 1'b0;
        // strap moves after power-on and must not be seen
        strap = ~s;
    endtask
    task automatic bus_rst();
        @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
    endtask
    task automatic pulse();
        @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic wake_is(input logic exp);
        for (int i = 0; i < 5 && wake_assert !== exp; i++)
            @(negedge clk);
        chk({15'h0000, wake_assert}, {15'h0000, exp});
    endtask
    initial
    begin
        por(1'b1);
        chk({15'h0000, cold_standby_support}, 16'h0001);
        rd(CAP, 16'h01ca);
        rd(CSR, 16'h0000);
        wr(CAP, 2'h3, 16'hffff);
        rd(CAP, 16'h01ca);
        rd(8'h40, 16'h0000);
        $display("capability test done");
        for (int s = 0; s < 4; s++)
        begin
            wr(CSR, 2'h3, {14'h0000, s[1:0]});
            chk({14'h0000, power_state}, {14'h0000, s[1:0]});
            rd(CSR, {14'h0000, s[1:0]});
        end
        wr(CSR, 2'h3, 16'h7ffc);
        rd(CSR, 16'h0100);
        wake_is(1'b0);
        pulse();
        rd(CSR, 16'h8100);
        wake_is(1'b1);
        wr(CSR, 2'h3, 16'h0103);
        rd(CSR, 16'h8103);
        bus_rst();
        rd(CSR, 16'h8100);
        wr(CSR, 2'h1, 16'h8002);
        rd(CSR, 16'h8102);
        wr(CSR, 2'h3, 16'h8100);
        rd(CSR, 16'h0100);
        wake_is(1'b0);
        wr(CSR, 2'h3, 16'h0000);
        pulse();
        rd(CSR, 16'h8000);
        wake_is(1'b0);
        $display("wake test done");
        por(1'b0);
        chk({15'h0000, cold_standby_support}, 16'h0000);
        rd(CAP, 16'h000a);
        wr(CSR, 2'h3, 16'h0100);
        pulse();
        rd(CSR, 16'h8100);
        bus_rst();
        rd(CSR, 16'h0000);
        $display("no cold standby test done");
        stop_test();
    end
endmodule // pci_power_mgmt_regs_bench
`default_nettype wire

//--- sim/ppm_wake_src.sv
// system-side source of wake events
`timescale 1ns/100ps
`default_nettype none
module ppm_wake_src
(
    // clock and command
    input wire logic clk,
    input wire logic fire,
    // toward the function
    output logic wake_event
);
    initial wake_event = 1'b0;
    // launched by nba so the function sees it one edge later
    always @(posedge clk)
    begin
        wake_event <= fire;
    end
endmodule // ppm_wake_src
`default_nettype wire
